// >>> design/xbus_decode_io_recovery.sv
// X-bus chip-select decode and ISA I/O recovery pacing with APB registers
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// Operation
// - Minimum 3.5 ISA clocks between I/O commands
// - 8-bit field adds 1..7, zero adds 8
// - Bit 2 enables extra 16-bit recovery
// - 16-bit field: 00=3, 01=1, 10=2, 11=4
// - Cleared decode bit blocks select and output enable
// - Bit 10 decodes ports 62h/66h
// - Bit 9 forwards 512K BIOS, upper lines ones
// - Bit 9 clear blocks 512K BIOS select
// - Bit 8 selects APIC window, forwards
// - Bit 8 clear ignores APIC window
// - Never select APIC for ISA masters
// - APIC disabled turns pins into GPIO; reset loads APIC_PIN_OE with the APIC bit clear
// - Bit 7 forwards 384K BIOS, upper lines ones
// - Bit 7 clear blocks 384K BIOS select
module xbus_decode_io_recovery
   import xbus_decode_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Bus cycle to decode
   input wire bus_cycle_t cycle,
   input wire logic [31:0] apic_base,
   // ISA command pacing
   input wire logic isa_bus_clock,
   input wire logic io_read_cmd_n,
   input wire logic io_write_cmd_n,
   input wire logic cmd_is_16bit,
   input wire logic cmd_sub_cycle,
   output logic recovery_hold,
   // X-bus selects
   output logic boot_rom_select_n,
   output logic microcontroller_select_n,
   output logic int_router_select_n,
   output logic xbus_output_enable_n,
   output logic positive_decode,
   output logic forward_to_isa,
   output logic [3:0] isa_upper_addr,
   // Shared pins
   input wire pin_group_t gpio,
   input wire logic [5:0] apic_fn_out,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe
);

   // ********************************************
   // State
   // ********************************************
   typedef struct packed {
      logic [7:0] recovery_reg;
      logic [15:0] chip_sel_reg;
      logic ready;
      logic [31:0] rdata;
      logic err;
      logic isa_clk_prev;
      logic cmd_prev;
      logic cmd_wide;
      logic cmd_sub;
      logic [4:0] count;
      logic hold;
      logic bios_n;
      logic mc_n;
      logic apic_n;
      logic xoe_n;
      logic pos_dec;
      logic fwd;
      logic [3:0] upper;
      logic [5:0] pins;
      logic [5:0] oes;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Extra ISA clocks for an 8-bit command
   function automatic logic [3:0] extra8(input logic [2:0] code);
      extra8 = (code == 3'h0) ? REC8_ZERO_CODE_CLOCKS : {1'b0, code};
   endfunction : extra8

   // Extra ISA clocks for a 16-bit command
   function automatic logic [3:0] extra16(input logic [1:0] code);
      extra16 = (code == 2'h0) ? REC16_ZERO_CODE_CLOCKS
                               : ((code == 2'h3) ? 4'h4 : {2'h0, code});
   endfunction : extra16

   // Whole recovery, in half-periods, for a finished command
   function automatic logic [4:0] recovery_half(input logic [7:0] rt, input logic wide,
                                                input logic sub);
      logic [3:0] extra;
      extra = 4'h0;
      if (!sub) begin
         if (wide && rt[REC16_EN_BIT]) begin
            extra = extra16(rt[REC16_LSB +: 2]);
         end else if (!wide && rt[REC8_EN_BIT]) begin
            extra = extra8(rt[REC8_LSB +: 3]);
         end
      end
      recovery_half = BASE_HALF_PERIODS + 5'({extra, 1'b0});
   endfunction : recovery_half

   logic setup_phase;
   logic write_now;
   logic cmd_active;
   logic isa_edge;
   logic pci_mem;
   logic in_bios512;
   logic in_bios384;
   logic in_apic;
   logic in_mc;
   logic sel_bios;
   logic sel_mc;
   logic sel_apic;

   assign setup_phase = psel && !penable;
   assign write_now = psel && penable && state_reg.ready && pwrite;
   assign cmd_active = !io_read_cmd_n || !io_write_cmd_n;
   assign isa_edge = isa_bus_clock != state_reg.isa_clk_prev;
   assign pci_mem = cycle.valid && cycle.is_mem && !cycle.from_isa;
   assign in_bios512 = cycle.addr[31:19] == BIOS_HI_TAG;
   assign in_bios384 = (cycle.addr[31:19] == BIOS_TOP_TAG)
                       && (cycle.addr[18:17] != BIOS_TOP_HOLE);
   assign in_apic = (cycle.addr & APIC_WINDOW_MASK) == (apic_base & APIC_WINDOW_MASK);
   assign in_mc = (cycle.addr[15:0] == MC_PORT_DATA) || (cycle.addr[15:0] == MC_PORT_CMD);
   // Decode bits gate each select; a cleared bit blocks select and output enable
   assign sel_bios = pci_mem && ((in_bios512 && state_reg.chip_sel_reg[BIOS512_EN_BIT])
                     || (in_bios384 && state_reg.chip_sel_reg[BIOS384_EN_BIT]));
   assign sel_mc = cycle.valid && cycle.is_io && in_mc
                   && state_reg.chip_sel_reg[MC_EN_BIT];
   // Only PCI-side memory cycles can reach the APIC window
   assign sel_apic = pci_mem && in_apic && state_reg.chip_sel_reg[APIC_EN_BIT];

   // ********************************************
   // Next state
   // ********************************************
   always_comb begin
      state_next = state_reg;
      // APB: no wait states, data and error ready in the first access phase
      state_next.ready = setup_phase;
      state_next.err = 1'b0;
      state_next.rdata = 32'h0;
      if (setup_phase) begin
         unique case (paddr)
            RECOVERY_ADDR: state_next.rdata = {24'h0, state_reg.recovery_reg};
            CHIP_SEL_ADDR: state_next.rdata = {16'h0, state_reg.chip_sel_reg};
            STATUS_ADDR: state_next.rdata = {19'h0, state_reg.count, 7'h0, state_reg.hold};
            default: state_next.err = 1'b1;
         endcase
         if (paddr[1:0] != 2'h0) begin
            state_next.err = 1'b1;
         end
      end else begin
         state_next.rdata = state_reg.rdata;
      end
      if (write_now && !state_reg.err) begin
         if (paddr == RECOVERY_ADDR && pstrb[0]) begin
            state_next.recovery_reg = pwdata[7:0];
         end
         if (paddr == CHIP_SEL_ADDR) begin
            if (pstrb[0]) begin
               state_next.chip_sel_reg[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               state_next.chip_sel_reg[15:8] = pwdata[15:8] & CHIP_SEL_MASK[15:8];
            end
         end
      end

      // Recovery pacing on both ISA clock edges
      state_next.isa_clk_prev = isa_bus_clock;
      state_next.cmd_prev = cmd_active;
      if (cmd_active) begin
         state_next.cmd_wide = cmd_is_16bit;
         state_next.cmd_sub = cmd_sub_cycle;
      end
      if (state_reg.cmd_prev && !cmd_active) begin
         state_next.count = recovery_half(state_reg.recovery_reg, state_reg.cmd_wide,
                                          state_reg.cmd_sub);
      end else if (isa_edge && state_reg.count != 5'h0) begin
         state_next.count = state_reg.count - 5'h1;
      end
      // Hold is raised in the cycle the count loads so no command slips in
      state_next.hold = (state_next.count != 5'h0);

      // Chip selects and output enable
      state_next.bios_n = !sel_bios;
      state_next.mc_n = !sel_mc;
      state_next.apic_n = !sel_apic;
      state_next.xoe_n = !(sel_bios || sel_mc || sel_apic);
      state_next.pos_dec = sel_bios || sel_mc || sel_apic;
      state_next.fwd = sel_bios || sel_apic;
      state_next.upper = sel_bios ? UPPER_ADDR_ONES : cycle.addr[23:20];

      // Shared pins: APIC function or plain GPIO
      if (state_reg.chip_sel_reg[APIC_EN_BIT]) begin
         state_next.pins = apic_fn_out;
         state_next.pins[PIN_SELECT] = !sel_apic;
         state_next.oes = APIC_PIN_OE;
      end else begin
         state_next.pins = gpio.drive;
         state_next.oes = gpio.enable;
      end
   end

   // ********************************************
   // Registers
   // ********************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '{recovery_reg: RECOVERY_RESET, chip_sel_reg: CHIP_SEL_RESET,
                        bios_n: 1'b1, mc_n: 1'b1, apic_n: 1'b1, xoe_n: 1'b1,
                        pins: 6'h01, oes: APIC_PIN_OE, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign pready = state_reg.ready;
   assign prdata = state_reg.rdata;
   assign pslverr = state_reg.err;
   assign recovery_hold = state_reg.hold;
   assign boot_rom_select_n = state_reg.bios_n;
   assign microcontroller_select_n = state_reg.mc_n;
   assign int_router_select_n = state_reg.apic_n;
   assign xbus_output_enable_n = state_reg.xoe_n;
   assign positive_decode = state_reg.pos_dec;
   assign forward_to_isa = state_reg.fwd;
   assign isa_upper_addr = state_reg.upper;
   assign pin_out = state_reg.pins;
   assign pin_oe = state_reg.oes;

   // ********************************************
   // Assertions
   // ********************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   recovery_base_a: assert property (
      (state_reg.cmd_prev && !cmd_active && state_reg.cmd_sub)
      |=> (state_reg.count == BASE_HALF_PERIODS))
      else $error("sub-cycle recovery not at base");
   recovery_8bit_a: assert property (
      (state_reg.cmd_prev && !cmd_active && !state_reg.cmd_sub && !state_reg.cmd_wide
       && state_reg.recovery_reg[REC8_EN_BIT] && state_reg.recovery_reg[5:3] == 3'h0)
      |=> (state_reg.count == 5'h17))
      else $error("8-bit zero code not eight clocks");
   recovery_16off_a: assert property (
      (state_reg.cmd_prev && !cmd_active && state_reg.cmd_wide
       && !state_reg.recovery_reg[REC16_EN_BIT]) |=> (state_reg.count == 5'h07))
      else $error("16-bit disabled recovery not base");
   recovery_16bit_a: assert property (
      (state_reg.cmd_prev && !cmd_active && !state_reg.cmd_sub && state_reg.cmd_wide
       && state_reg.recovery_reg[REC16_EN_BIT] && state_reg.recovery_reg[1:0] == 2'h0)
      |=> (state_reg.count == 5'h0D))
      else $error("16-bit zero code not three clocks");
   hold_counts_a: assert property (
      (state_reg.count != 5'h0 && !isa_edge && !(state_reg.cmd_prev && !cmd_active))
      |=> (recovery_hold && state_reg.count == $past(state_reg.count)))
      else $error("recovery count moved without clock edge");
   mc_decode_a: assert property (
      (cycle.valid && cycle.is_io && cycle.addr[15:0] == MC_PORT_CMD)
      |=> (microcontroller_select_n == !$past(state_reg.chip_sel_reg[MC_EN_BIT])))
      else $error("microcontroller select wrong");
   bios_block_a: assert property (
      (in_bios512 && !state_reg.chip_sel_reg[BIOS512_EN_BIT] && !in_bios384)
      |=> boot_rom_select_n)
      else $error("boot select in disabled region");
   bios_upper_a: assert property (
      !boot_rom_select_n |-> (isa_upper_addr == UPPER_ADDR_ONES && forward_to_isa
                              && !xbus_output_enable_n))
      else $error("boot cycle not aliased high");
   apic_isa_a: assert property (
      cycle.from_isa |=> int_router_select_n)
      else $error("apic select for isa master");
   apic_gpio_a: assert property (
      (presetn && !state_reg.chip_sel_reg[APIC_EN_BIT]) |=> (pin_oe == $past(gpio.enable)
                                               && pin_out == $past(gpio.drive)))
      else $error("shared pins not in gpio mode");
   xoe_cause_a: assert property (
      !xbus_output_enable_n |-> (!boot_rom_select_n || !microcontroller_select_n
                                 || !int_router_select_n))
      else $error("output enable with no select");

   // Enable bits gate every select, both ways
   mc_block_a: assert property (
      (cycle.valid && cycle.is_io && !cycle.is_mem && in_mc
       && !state_reg.chip_sel_reg[MC_EN_BIT])
      |=> (microcontroller_select_n && !positive_decode))
      else $error("microcontroller select while disabled");
   bios384_block_a: assert property (
      (pci_mem && in_bios384 && !state_reg.chip_sel_reg[BIOS384_EN_BIT]) |=> boot_rom_select_n)
      else $error("boot select in disabled upper region");
   bios384_fwd_a: assert property (
      (pci_mem && in_bios384 && state_reg.chip_sel_reg[BIOS384_EN_BIT])
      |=> (!boot_rom_select_n && forward_to_isa && isa_upper_addr == UPPER_ADDR_ONES))
      else $error("enabled upper region not forwarded");
   bios512_fwd_a: assert property (
      (pci_mem && in_bios512 && state_reg.chip_sel_reg[BIOS512_EN_BIT])
      |=> (!boot_rom_select_n && forward_to_isa && !xbus_output_enable_n))
      else $error("enabled extended region not forwarded");
   apic_block_a: assert property (
      !state_reg.chip_sel_reg[APIC_EN_BIT] |=> int_router_select_n)
      else $error("apic select while disabled");
   apic_select_a: assert property (
      (pci_mem && in_apic && state_reg.chip_sel_reg[APIC_EN_BIT])
      |=> (!int_router_select_n && forward_to_isa && !xbus_output_enable_n))
      else $error("apic window not selected");
   apic_pins_a: assert property (
      state_reg.chip_sel_reg[APIC_EN_BIT] |=> (pin_oe == APIC_PIN_OE))
      else $error("shared pins not in apic mode");
   hold_release_a: assert property (
      (state_reg.count == 5'h01 && isa_edge && !(state_reg.cmd_prev && !cmd_active))
      |=> !recovery_hold)
      else $error("recovery hold outlived its count");
   recovery_code8_a: assert property (
      (state_reg.cmd_prev && !cmd_active && !state_reg.cmd_sub && !state_reg.cmd_wide
       && state_reg.recovery_reg[REC8_EN_BIT] && state_reg.recovery_reg[5:3] != 3'h0)
      |=> (state_reg.count == BASE_HALF_PERIODS + {$past(state_reg.recovery_reg[5:3]), 1'b0}))
      else $error("8-bit recovery code not added");
   recovery_code16_a: assert property (
      (state_reg.cmd_prev && !cmd_active && !state_reg.cmd_sub && state_reg.cmd_wide
       && state_reg.recovery_reg[REC16_EN_BIT] && state_reg.recovery_reg[1:0] == 2'h3)
      |=> (state_reg.count == 5'h0F))
      else $error("16-bit code three not four clocks");

   bios_cycle_c: cover property (!boot_rom_select_n);
   apic_cycle_c: cover property (!int_router_select_n);
   recovery_run_c: cover property (recovery_hold ##1 !recovery_hold);
   apb_write_c: cover property (write_now && paddr == RECOVERY_ADDR);
   slave_error_c: cover property (pslverr);

endmodule : xbus_decode_io_recovery

// >>> design/xbus_decode_pkg.sv
// Package: register map, field layout and decode constants for the X-bus decode block
package xbus_decode_pkg;

   // ********************************************
   // Register indices and byte addresses
   // ********************************************
   localparam logic [11:0] RECOVERY_INDEX = 12'h04C;
   localparam logic [11:0] CHIP_SEL_INDEX = 12'h04E;
   localparam logic [11:0] STATUS_INDEX = 12'h050;
   localparam logic [11:0] RECOVERY_ADDR = 12'(RECOVERY_INDEX * 4);
   localparam logic [11:0] CHIP_SEL_ADDR = 12'(CHIP_SEL_INDEX * 4);
   localparam logic [11:0] STATUS_ADDR = 12'(STATUS_INDEX * 4);

   // ********************************************
   // Reset values and field positions
   // ********************************************
   localparam logic [7:0] RECOVERY_RESET = 8'h4D;
   localparam logic [15:0] CHIP_SEL_RESET = 16'h0003;
   localparam logic [15:0] CHIP_SEL_MASK = 16'h07FF;
   localparam int REC8_EN_BIT = 6;
   localparam int REC8_LSB = 3;
   localparam int REC16_EN_BIT = 2;
   localparam int REC16_LSB = 0;
   localparam int MC_EN_BIT = 10;
   localparam int BIOS512_EN_BIT = 9;
   localparam int APIC_EN_BIT = 8;
   localparam int BIOS384_EN_BIT = 7;

   // ********************************************
   // Recovery timing: base in ISA clock half-periods, zero-code extras in ISA clocks
   // ********************************************
   localparam logic [4:0] BASE_HALF_PERIODS = 5'h07;
   localparam logic [3:0] REC8_ZERO_CODE_CLOCKS = 4'h8;
   localparam logic [3:0] REC16_ZERO_CODE_CLOCKS = 4'h3;

   // ********************************************
   // Address decode
   // ********************************************
   localparam logic [15:0] MC_PORT_DATA = 16'h0062;
   localparam logic [15:0] MC_PORT_CMD = 16'h0066;
   localparam logic [12:0] BIOS_HI_TAG = 13'h1FFE;
   localparam logic [12:0] BIOS_TOP_TAG = 13'h1FFF;
   localparam logic [1:0] BIOS_TOP_HOLE = 2'h3;
   localparam logic [31:0] APIC_BASE_DEFAULT = 32'hFEC00000;
   localparam logic [31:0] APIC_WINDOW_MASK = 32'hFFFFFFEF;
   localparam logic [3:0] UPPER_ADDR_ONES = 4'hF;

   // ********************************************
   // Shared-pin group: select, request, ack, timer, rtc, irq9
   // ********************************************
   localparam int PIN_COUNT = 6;
   localparam int PIN_SELECT = 0;
   localparam logic [5:0] APIC_PIN_OE = 6'h3D;

   typedef struct packed {
      logic valid;
      logic is_mem;
      logic is_io;
      logic from_isa;
      logic [31:0] addr;
   } bus_cycle_t;

   typedef struct packed {
      logic [5:0] drive;
      logic [5:0] enable;
   } pin_group_t;

endpackage : xbus_decode_pkg

// >>> tb/isa_side_model.sv
// ISA far side: free-running bus clock and a paced I/O command issuer
`timescale 1ns/1ps

// ********************************************
// ISA side model
// ********************************************
module isa_side_model
   import xbus_decode_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Command request from bench
   input wire logic start,
   input wire logic wide,
   input wire logic sub,
   input wire logic recovery_hold,
   // ISA side
   output logic isa_bus_clock,
   output logic io_read_cmd_n,
   output logic io_write_cmd_n,
   output logic cmd_is_16bit,
   output logic cmd_sub_cycle,
   output logic busy
);
   logic phase;
   logic [3:0] len;

   // No memory is placed in the aliased BIOS windows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 1'b0;
         isa_bus_clock <= 1'b0;
         io_read_cmd_n <= 1'b1;
         io_write_cmd_n <= 1'b1;
         cmd_is_16bit <= 1'b0;
         cmd_sub_cycle <= 1'b0;
         busy <= 1'b0;
         len <= 4'h0;
      end else begin
         // Bus clock at a quarter of pclk, runs free
         phase <= !phase;
         if (phase) begin
            isa_bus_clock <= !isa_bus_clock;
         end
         // Next command waits for the hold to clear
         if (start && !busy && !recovery_hold) begin
            busy <= 1'b1;
            len <= 4'h6;
            io_read_cmd_n <= sub;
            io_write_cmd_n <= !sub;
            cmd_is_16bit <= wide;
            cmd_sub_cycle <= sub;
         end else if (len != 4'h0) begin
            len <= len - 4'h1;
            if (len == 4'h1) begin
               io_read_cmd_n <= 1'b1;
               io_write_cmd_n <= 1'b1;
               busy <= 1'b0;
            end
         end
      end
   end
endmodule : isa_side_model

// >>> tb/xbus_decode_io_recovery_tb.sv
// Testbench: registers, decode, shared pins and recovery pacing
`timescale 1ns/1ps

module xbus_decode_io_recovery_tb
   import xbus_decode_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb, isa_upper_addr;
   bus_cycle_t cycle;
   pin_group_t gpio;
   logic [5:0] apic_fn_out, pin_out, pin_oe;
   logic isa_bus_clock, io_read_cmd_n, io_write_cmd_n, cmd_is_16bit, cmd_sub_cycle;
   logic recovery_hold, boot_rom_select_n, microcontroller_select_n, int_router_select_n;
   logic xbus_output_enable_n, positive_decode, forward_to_isa, start, wide, sub, busy, e, on;
   logic last, seen;
   logic [31:0] apic_base;
   int err_count, num_checks, i, c, n, k;
   logic [31:0] va [5] = '{32'hFFF00000, 32'hFFF80000, 32'hFEC00010, 32'hFEC00000, 32'h00000066};
   logic [7:0] rv [9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h03, 8'h40, 8'h68, 8'h78, 8'h4D};
   int rn [9] = '{13, 9, 11, 15, 7, 23, 17, 21, 7};

   xbus_decode_io_recovery dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cycle(cycle), .apic_base(apic_base),
      .isa_bus_clock(isa_bus_clock), .io_read_cmd_n(io_read_cmd_n),
      .io_write_cmd_n(io_write_cmd_n), .cmd_is_16bit(cmd_is_16bit),
      .cmd_sub_cycle(cmd_sub_cycle), .recovery_hold(recovery_hold),
      .boot_rom_select_n(boot_rom_select_n), .microcontroller_select_n(microcontroller_select_n),
      .int_router_select_n(int_router_select_n), .xbus_output_enable_n(xbus_output_enable_n),
      .positive_decode(positive_decode), .forward_to_isa(forward_to_isa),
      .isa_upper_addr(isa_upper_addr), .gpio(gpio), .apic_fn_out(apic_fn_out),
      .pin_out(pin_out), .pin_oe(pin_oe));

   isa_side_model far_side (.pclk(pclk), .presetn(presetn), .start(start), .wide(wide),
      .sub(sub), .recovery_hold(recovery_hold), .isa_bus_clock(isa_bus_clock),
      .io_read_cmd_n(io_read_cmd_n), .io_write_cmd_n(io_write_cmd_n),
      .cmd_is_16bit(cmd_is_16bit), .cmd_sub_cycle(cmd_sub_cycle), .busy(busy));

   // ********************************************
   // Tasks
   // ********************************************
   task check(input string name, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Setup then access until pready; the wait has no assumed length
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task final_report;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = !pclk;
   end

   // Whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      final_report;
   end

   // ********************************************
   // Main sequence
   // ********************************************
   initial begin
      {presetn, psel, penable, pwrite, start, wide, sub} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      cycle = '0;
      apic_base = APIC_BASE_DEFAULT;
      gpio = '0;
      apic_fn_out = 6'h14;
      err_count = 0;
      num_checks = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, RECOVERY_ADDR, 32'h0);
      check("recovery reset", r, 32'h4D);
      check("recovery no error", e, 1'b0);
      apb(1'b0, CHIP_SEL_ADDR, 32'h0);
      check("chip select reset", r, 32'h3);
      apb(1'b1, CHIP_SEL_ADDR, 32'hFFFF);
      apb(1'b0, CHIP_SEL_ADDR, 32'h0);
      check("chip select reserved", r, 32'h07FF);
      apb(1'b0, 12'h200, 32'h0);
      check("unmapped error", e, 1'b1);
      apb(1'b0, RECOVERY_ADDR + 12'h2, 32'h0);
      check("misaligned error", e, 1'b1);
      check("misaligned data", r, 32'h0);
      for (c = 0; c < 2; c++) begin
         apb(1'b1, CHIP_SEL_ADDR, c == 0 ? 32'h0780 : 32'h0);
         on = (c == 0);
         for (i = 0; i < 5; i++) begin
            @(posedge pclk);
            cycle <= '{1'b1, i != 4, i == 4, i == 3, va[i]};
            repeat (2) @(posedge pclk);
            check("boot select", boot_rom_select_n, !(on && i < 2));
            check("apic select", int_router_select_n, !(on && i == 2));
            check("mc select", microcontroller_select_n, !(on && i == 4));
            check("xbus_output_enable_n", xbus_output_enable_n, !(on && i != 3));
            check("forward_to_isa", forward_to_isa, on && i < 3);
            check("positive_decode", positive_decode, on && i != 3);
            if (on && i < 2) check("upper", isa_upper_addr, UPPER_ADDR_ONES);
         end
         cycle <= '0;
      end
      gpio <= '{6'h2A, 6'h15};
      repeat (3) @(posedge pclk);
      check("gpio out", pin_out, 6'h2A);
      check("gpio oe", pin_oe, 6'h15);
      apb(1'b1, CHIP_SEL_ADDR, 32'h0100);
      repeat (2) @(posedge pclk);
      check("apic oe", pin_oe, APIC_PIN_OE);
      check("apic out", pin_out[5:1], apic_fn_out[5:1]);
      // Relocated window still answers at base plus 10h
      apic_base <= 32'hFEC01000;
      cycle <= '{1'b1, 1'b1, 1'b0, 1'b0, 32'hFEC01010};
      repeat (2) @(posedge pclk);
      check("relocated apic", int_router_select_n, 1'b0);
      check("apic pin select", pin_out[0], 1'b0);
      cycle <= '0;
      // Hold length counted in ISA clock half-periods seen while held
      for (i = 0; i < 9; i++) begin
         apb(1'b1, RECOVERY_ADDR, {24'h0, rv[i]});
         @(posedge pclk);
         wide <= (i < 5);
         sub <= (i == 8);
         start <= 1'b1;
         n = 0;
         seen = 1'b0;
         last = isa_bus_clock;
         for (k = 0; k < 400; k++) begin
            @(posedge pclk);
            if (busy === 1'b1) start <= 1'b0;
            if (recovery_hold === 1'b1) begin
               seen = 1'b1;
               if (isa_bus_clock !== last) n++;
            end else if (seen) break;
            last = isa_bus_clock;
         end
         check("hold half periods", n, rn[i]);
      end
      // Status read two clocks into a nine half-period hold
      @(posedge pclk);
      sub <= 1'b0;
      start <= 1'b1;
      do begin
         @(posedge pclk);
      end while (busy !== 1'b1);
      start <= 1'b0;
      do begin
         @(posedge pclk);
      end while (recovery_hold !== 1'b1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      check("status during hold", r, 32'h00000801);
      final_report;
   end
endmodule : xbus_decode_io_recovery_tb
